/* File: core/i2c_irq_pkg.sv */
package i2c_irq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ABORT_CLR    = 32'h5000_1554;
  localparam logic [ADDR_W-1:0] ADDR_RX_DONE_CLR  = 32'h5000_1558;
  localparam logic [ADDR_W-1:0] ADDR_BUSY_CLR     = 32'h5000_155C;
  localparam logic [ADDR_W-1:0] ADDR_STOP_CLR     = 32'h5000_1560;
  localparam logic [ADDR_W-1:0] ADDR_START_CLR    = 32'h5000_1564;
  localparam logic [ADDR_W-1:0] ADDR_BCAST_CLR    = 32'h5000_1568;
  localparam logic [ADDR_W-1:0] ADDR_ON_OFF       = 32'h5000_156C;
  localparam logic [ADDR_W-1:0] ADDR_ABORT_CAUSE  = 32'h5000_1580;
  localparam logic [ADDR_W-1:0] ADDR_RAW_STATUS   = 32'h5000_15C0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 32'h5000_15C4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ABORT     = 6;
  localparam int unsigned BIT_RX_DONE   = 7;
  localparam int unsigned BIT_ACTIVITY  = 8;
  localparam int unsigned BIT_STOP      = 9;
  localparam int unsigned BIT_START     = 10;
  localparam int unsigned BIT_BCAST     = 11;
  localparam int unsigned BIT_CAUSE_KEEP = 9;
  localparam int unsigned BIT_FIELD     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]  RAW_RESET   = 16'h0000;
  localparam logic [REG_W-1:0]  MASK_RESET  = 16'h0000;
  localparam logic [REG_W-1:0]  CAUSE_RESET = 16'h0000;
  localparam logic              ON_RESET    = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO  = 32'h0000_0000;

  // Enable reaches the core after this many cycles (pipeline depth)
  localparam int unsigned ENABLE_DELAY_CYCLES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_RUN   = 3'b010,
    ST_DRAIN = 3'b100
  } ctrl_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

  typedef struct packed {
    logic abort;
    logic rx_done;
    logic bcast;
  } core_event_t;

  typedef struct packed {
    logic master_active;
    logic slave_active;
    logic byte_busy;
    logic receiving;
  } core_status_t;

  typedef struct packed {
    bus_pins_t          sync1;
    bus_pins_t          sync2;
    bus_pins_t          last;
    logic               bus_busy;
    logic               on_req;
    logic               on_pipe;
    ctrl_state_t        st;
    logic [REG_W-1:0]   raw;
    logic [REG_W-1:0]   mask;
    logic [REG_W-1:0]   cause;
    logic               abort_hold;
    logic               pready;
    logic               pslverr;
    logic [DATA_W-1:0]  prdata;
    logic               irq;
    logic               tx_flush;
    logic               rx_flush;
    logic               core_enable;
    logic               graceful_stop;
    logic               rx_nack;
  } block_state_t;

  function automatic logic [REG_W-1:0] one_hot(input int unsigned pos);
    logic [REG_W-1:0] v;
    v = '0;
    v[pos] = 1'b1;
    return v;
  endfunction : one_hot

endpackage : i2c_irq_pkg

/* File: core/i2c_irq_ctrl.sv */
`timescale 1ns/1ns

module i2c_irq_ctrl (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  // APB slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [i2c_irq_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [i2c_irq_pkg::DATA_W-1:0] pwdata_i,
  output logic      [i2c_irq_pkg::DATA_W-1:0] prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  // Bus pins, asynchronous
  input  wire i2c_irq_pkg::bus_pins_t        pins_i,
  // Controller core, same clock
  input  wire i2c_irq_pkg::core_event_t      core_event_i,
  input  wire i2c_irq_pkg::core_status_t     core_status_i,
  input  wire logic [i2c_irq_pkg::REG_W-1:0] abort_cause_i,
  // Controller core controls
  output logic                               core_enable_o,
  output logic                               tx_flush_o,
  output logic                               rx_flush_o,
  output logic                               graceful_stop_o,
  output logic                               rx_nack_o,
  // Interrupt
  output logic                               irq_o
);
  import i2c_irq_pkg::*;

  block_state_t      s;
  block_state_t      next_s;

  logic              setup;
  logic              done;
  logic              rd_done;
  logic              wr_done;
  logic              start_seen;
  logic              stop_seen;
  logic              active;
  logic              addr_hit;
  logic [REG_W-1:0]  set_v;
  logic [REG_W-1:0]  clr_v;
  logic [REG_W-1:0]  rd_val;

  assign setup   = psel_i & ~penable_i;
  assign done    = psel_i & penable_i & s.pready;
  assign rd_done = done & ~pwrite_i;
  assign wr_done = done & pwrite_i;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    addr_hit = 1'b1;
    rd_val   = '0;
    unique case (paddr_i)
      ADDR_ABORT_CLR:   rd_val[BIT_FIELD] = s.raw[BIT_ABORT];
      ADDR_RX_DONE_CLR: rd_val[BIT_FIELD] = s.raw[BIT_RX_DONE];
      ADDR_BUSY_CLR:    rd_val[BIT_FIELD] = s.raw[BIT_ACTIVITY];
      ADDR_STOP_CLR:    rd_val[BIT_FIELD] = s.raw[BIT_STOP];
      ADDR_START_CLR:   rd_val[BIT_FIELD] = s.raw[BIT_START];
      ADDR_BCAST_CLR:   rd_val[BIT_FIELD] = s.raw[BIT_BCAST];
      ADDR_ON_OFF:      rd_val[BIT_FIELD] = s.on_req;
      ADDR_ABORT_CAUSE: rd_val = s.cause;
      ADDR_RAW_STATUS:  rd_val = s.raw;
      ADDR_IRQ_MASK:    rd_val = s.mask;
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus watch: start and stop conditions from synchronised pins
  // ----------------------------------------------------------------
  always_comb begin
    start_seen = s.last.scl & s.sync2.scl & s.last.sda & ~s.sync2.sda;
    stop_seen  = s.last.scl & s.sync2.scl & ~s.last.sda & s.sync2.sda;
    active     = s.bus_busy | core_status_i.master_active
                 | core_status_i.slave_active;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Only sync2 reads sync1
    next_s.sync1 = pins_i;
    next_s.sync2 = s.sync1;
    next_s.last  = s.sync2;

    if (start_seen) begin
      next_s.bus_busy = 1'b1;
    end else if (stop_seen) begin
      next_s.bus_busy = 1'b0;
    end

    // Enable register write, then one pipe stage, then the state flop
    if (wr_done && paddr_i == ADDR_ON_OFF) begin
      next_s.on_req = pwdata_i[BIT_FIELD];
    end
    next_s.on_pipe = s.on_req;

    unique case (s.st)
      ST_OFF: begin
        if (s.on_pipe) begin
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!s.on_pipe) begin
          next_s.st = active ? ST_DRAIN : ST_OFF;
        end
      end
      ST_DRAIN: begin
        if (s.on_pipe) begin
          next_s.st = ST_RUN;
        end else if (!active) begin
          next_s.st = ST_OFF;
        end
      end
    endcase

    // Events from core and pins
    set_v = '0;
    if (core_event_i.abort) begin
      set_v = set_v | one_hot(BIT_ABORT);
    end
    if (core_event_i.rx_done) begin
      set_v = set_v | one_hot(BIT_RX_DONE);
    end
    if (core_event_i.bcast) begin
      set_v = set_v | one_hot(BIT_BCAST);
    end
    if (start_seen) begin
      set_v = set_v | one_hot(BIT_START);
    end
    if (stop_seen) begin
      set_v = set_v | one_hot(BIT_STOP);
    end
    if (active) begin
      set_v = set_v | one_hot(BIT_ACTIVITY);
    end

    // Clears: read-to-clear, write-one-to-clear and hardware
    clr_v = '0;
    if (rd_done) begin
      unique case (paddr_i)
        ADDR_ABORT_CLR:   clr_v = one_hot(BIT_ABORT);
        ADDR_RX_DONE_CLR: clr_v = one_hot(BIT_RX_DONE);
        ADDR_BUSY_CLR: begin
          if (!active) begin
            clr_v = one_hot(BIT_ACTIVITY);
          end
        end
        ADDR_STOP_CLR:    clr_v = one_hot(BIT_STOP);
        ADDR_START_CLR:   clr_v = one_hot(BIT_START);
        ADDR_BCAST_CLR:   clr_v = one_hot(BIT_BCAST);
        default: begin
          clr_v = '0;
        end
      endcase
    end
    if (wr_done && paddr_i == ADDR_RAW_STATUS) begin
      clr_v = clr_v | pwdata_i[REG_W-1:0];
    end
    if (s.st == ST_OFF && !active) begin
      clr_v = clr_v | one_hot(BIT_ACTIVITY);
    end

    // Set wins over clear; the activity bit also clears by hardware while off and idle
    next_s.raw = (s.raw & ~clr_v) | set_v;

    if (wr_done && paddr_i == ADDR_IRQ_MASK) begin
      next_s.mask = pwdata_i[REG_W-1:0];
    end

    // Abort cause and transmit hold-off
    if (rd_done && paddr_i == ADDR_ABORT_CLR) begin
      next_s.cause = CAUSE_RESET;
      // Cause bit 9 survives while its source still reports it
      next_s.cause[BIT_CAUSE_KEEP] = abort_cause_i[BIT_CAUSE_KEEP];
      next_s.abort_hold = 1'b0;
    end
    if (core_event_i.abort) begin
      next_s.cause      = next_s.cause | abort_cause_i;
      next_s.abort_hold = 1'b1;
    end

    // Core controls; on disable the byte in flight finishes before flushing
    next_s.core_enable   = (next_s.st == ST_RUN);
    next_s.graceful_stop = (next_s.st == ST_DRAIN);
    next_s.rx_nack       = (next_s.st == ST_DRAIN)
                           & core_status_i.receiving;
    next_s.rx_flush      = (next_s.st != ST_RUN)
                           & ~core_status_i.byte_busy;
    next_s.tx_flush      = next_s.abort_hold | next_s.rx_flush;

    next_s.irq = |(next_s.raw & next_s.mask);

    // APB answer: zero wait states, prepared in the setup cycle
    next_s.pready  = setup;
    next_s.pslverr = setup & ~addr_hit;
    next_s.prdata  = RDATA_ZERO;
    if (setup && !pwrite_i) begin
      next_s.prdata = {{(DATA_W-REG_W){1'b0}}, rd_val};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s               <= '0;
      s.on_req        <= ON_RESET;
      s.on_pipe       <= ON_RESET;
      s.st            <= ST_OFF;
      s.raw           <= RAW_RESET;
      s.mask          <= MASK_RESET;
      s.cause         <= CAUSE_RESET;
      s.prdata        <= RDATA_ZERO;
      s.sync1         <= '1;
      s.sync2         <= '1;
      s.last          <= '1;
      s.tx_flush      <= 1'b1;
      s.rx_flush      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o        = s.prdata;
  assign pready_o        = s.pready;
  assign pslverr_o       = s.pslverr;
  assign core_enable_o   = s.core_enable;
  assign tx_flush_o      = s.tx_flush;
  assign rx_flush_o      = s.rx_flush;
  assign graceful_stop_o = s.graceful_stop;
  assign rx_nack_o       = s.rx_nack;
  assign irq_o           = s.irq;

endmodule : i2c_irq_ctrl

/* File: test/i2c_irq_ctrl_props.sv */
`timescale 1ns/1ns
module i2c_irq_ctrl_props
  import i2c_irq_pkg::*;
(
  // Clock, reset and APB
  input wire logic                          clk_i,
  input wire logic                          rst_b_i,
  input wire logic                          psel_i,
  input wire logic                          penable_i,
  input wire logic                          pwrite_i,
  input wire logic [i2c_irq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [i2c_irq_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [i2c_irq_pkg::DATA_W-1:0] prdata_o,
  input wire logic                          pready_o,
  input wire logic                          pslverr_o,
  // Core side
  input wire i2c_irq_pkg::bus_pins_t        pins_i,
  input wire i2c_irq_pkg::core_event_t      core_event_i,
  input wire i2c_irq_pkg::core_status_t     core_status_i,
  input wire logic [i2c_irq_pkg::REG_W-1:0] abort_cause_i,
  input wire logic                          core_enable_o,
  input wire logic                          tx_flush_o,
  input wire logic                          rx_flush_o,
  input wire logic                          graceful_stop_o,
  input wire logic                          rx_nack_o,
  input wire logic                          irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic xfer = psel_i && penable_i && pready_o;
  sequence wr_on(b);
    xfer && pwrite_i && paddr_i == ADDR_ON_OFF && pwdata_i[0] == b;
  endsequence
  sequence rd_at(a);
    xfer && !pwrite_i && paddr_i == a;
  endsequence
  setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  idle_data_a: assert property (!pready_o |-> prdata_o == RDATA_ZERO)
    else $error("read data outside access");
  clear_bits_a: assert property (pready_o && !pwrite_i && paddr_i inside
    {[ADDR_ABORT_CLR:ADDR_BCAST_CLR]} |-> prdata_o[31:1] == 31'h0)
    else $error("reserved bits set");
  on_delay_a: assert property (wr_on(1'b1) ##0 !core_enable_o
    |=> !core_enable_o[*2] ##1 core_enable_o) else $error("enable late");
  off_delay_a: assert property (wr_on(1'b0) ##0 core_enable_o
    |=> core_enable_o[*2] ##1 !core_enable_o) else $error("disable late");
  drain_off_a: assert property (graceful_stop_o |-> !core_enable_o)
    else $error("drain while enabled");
  nack_drain_a: assert property (rx_nack_o |-> graceful_stop_o)
    else $error("nack outside drain");
  flush_off_a: assert property ($fell(core_enable_o)
    && !core_status_i.byte_busy |-> ##[0:2] tx_flush_o && rx_flush_o)
    else $error("no flush on disable");
  busy_read_a: assert property (core_status_i.master_active[*3]
    ##0 rd_at(ADDR_BUSY_CLR) |-> prdata_o[0]) else $error("activity lost");
  abort_free_a: assert property (rd_at(ADDR_ABORT_CLR) ##0 core_enable_o
    && !core_event_i.abort |=> !tx_flush_o) else $error("tx still held");
endmodule : i2c_irq_ctrl_props

bind i2c_irq_ctrl i2c_irq_ctrl_props i_props (.*);

/* File: test/i2c_peer.sv */
`timescale 1ns/1ns
module i2c_peer
  import i2c_irq_pkg::*;
(
  input  wire logic              frame_i,
  output i2c_irq_pkg::bus_pins_t pins_o,
  output logic                   busy_o
);
  initial begin
    pins_o = 2'h3;
    busy_o = 1'b0;
  end
  // Pulled-up lines: clock stands high between frames
  always @(posedge frame_i) begin
    // Pin changes kept clear of the core clock edges
    #10;
    busy_o = 1'b1;
    pins_o.sda = 1'b0;
    #200;
    repeat (4) begin
      pins_o.scl = 1'b0;
      #100 pins_o.sda = ~pins_o.sda;
      #100 pins_o.scl = 1'b1;
      #200;
    end
    pins_o.scl = 1'b0;
    #100 pins_o.sda = 1'b0;
    #100 pins_o.scl = 1'b1;
    #200 pins_o.sda = 1'b1;
    busy_o = 1'b0;
  end
endmodule : i2c_peer

/* File: test/i2c_irq_ctrl_test.sv */
`timescale 1ns/1ns
module i2c_irq_ctrl_test;
  import i2c_irq_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_b = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         frame = 1'b0;
  logic [31:0]  paddr = 32'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready, pslverr, err, busy;
  logic         core_en, txf, rxf, gstop, nack, irq;
  bus_pins_t    pins;
  core_event_t  ev_q = 3'h0;
  core_status_t st_q = 4'h0;
  logic [15:0]  cause = 16'h0;
  int           failures = 0;
  int           checked = 0;
  always #25 clk_i = ~clk_i;
  i2c_peer i_peer (.frame_i(frame), .pins_o(pins), .busy_o(busy));
  i2c_irq_ctrl i_dut (.clk_i(clk_i), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pins_i(pins), .core_event_i(ev_q),
    .core_status_i(st_q), .abort_cause_i(cause), .core_enable_o(core_en),
    .tx_flush_o(txf), .rx_flush_o(rxf), .graceful_stop_o(gstop),
    .rx_nack_o(nack), .irq_o(irq));
  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      test_done();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic pulse(input core_event_t e);
    ev_q <= e;
    @(posedge clk_i);
    ev_q <= 3'h0;
    @(posedge clk_i);
  endtask : pulse
  // Bounded wait for the peer, then room for the pin synchroniser
  task automatic wpeer(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      failures++;
      test_done();
    end
    repeat (4) @(posedge clk_i);
  endtask : wpeer
  task automatic s_start();
    chk(txf, 1'b1);
    chk(core_en, 1'b0);
    rd(ADDR_ON_OFF, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0FC0);
    wr(ADDR_ON_OFF, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(core_en, 1'b1);
    chk(rxf, 1'b0);
  endtask : s_start
  task automatic s_abort();
    cause <= 16'h0201;
    pulse(3'h4);
    chk(irq, 1'b1);
    chk(txf, 1'b1);
    rd(ADDR_ABORT_CAUSE, 32'h0201);
    rd(ADDR_ABORT_CLR, 32'h1);
    rd(ADDR_ABORT_CAUSE, 32'h0200);
    chk(txf, 1'b0);
    cause <= 16'h0;
    rd(ADDR_ABORT_CLR, 32'h0);
    rd(ADDR_ABORT_CAUSE, 32'h0);
    chk(irq, 1'b0);
  endtask : s_abort
  task automatic s_events();
    core_event_t e[2] = '{3'h2, 3'h1};
    logic [31:0] a[2] = '{ADDR_RX_DONE_CLR, ADDR_BCAST_CLR};
    for (int i = 0; i < 2; i++) begin
      pulse(e[i]);
      wr(a[i], 32'h1);
      rd(a[i], 32'h1);
      rd(a[i], 32'h0);
    end
  endtask : s_events
  task automatic s_bus();
    frame <= 1'b1;
    wpeer(1'b1);
    frame <= 1'b0;
    rd(ADDR_START_CLR, 32'h1);
    rd(ADDR_BUSY_CLR, 32'h1);
    rd(ADDR_BUSY_CLR, 32'h1);
    wpeer(1'b0);
    rd(ADDR_STOP_CLR, 32'h1);
    rd(ADDR_BUSY_CLR, 32'h1);
    rd(ADDR_BUSY_CLR, 32'h0);
  endtask : s_bus
  task automatic s_drain();
    logic [31:0] r;
    st_q <= 4'hB;
    wr(ADDR_ON_OFF, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(gstop, 1'b1);
    chk(nack, 1'b1);
    chk(irq, 1'b1);
    rd(ADDR_BUSY_CLR, 32'h1);
    st_q <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk(gstop, 1'b0);
    chk({txf, rxf}, 2'h3);
    rd(ADDR_RAW_STATUS, 32'h0);
    apb(1'b0, 32'h5000_1600, 32'h0, r);
    chk(err, 1'b1);
    chk(r, 32'h0);
  endtask : s_drain
  // Quiet disable, then a reset in mid-run while enabled
  task automatic s_reset();
    wr(ADDR_ON_OFF, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(core_en, 1'b1);
    wr(ADDR_ON_OFF, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({txf, rxf}, 2'h3);
    chk(core_en, 1'b0);
    wr(ADDR_ON_OFF, 32'h1);
    repeat (4) @(posedge clk_i);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({core_en, txf, rxf}, 3'h3);
    rst_b <= 1'b1;
    @(posedge clk_i);
    rd(ADDR_ON_OFF, 32'h0);
    chk({txf, rxf}, 2'h3);
  endtask : s_reset
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b <= 1'b1;
    @(posedge clk_i);
    s_start();
    s_abort();
    s_events();
    s_bus();
    s_drain();
    s_reset();
    test_done();
  end
endmodule : i2c_irq_ctrl_test
